/* File: include/wsfb_map.svh */
// offsets, field positions, codes and cycle counts of the shifter block
`ifndef WSFB_MAP_SVH
`define WSFB_MAP_SVH
`define WSFB_OFF_INSTR   8'h00
`define WSFB_OFF_INDEX   8'h04
`define WSFB_OFF_PC      8'h08
`define WSFB_OFF_FLAGS   8'h0c
`define WSFB_OFF_STATUS  8'h10
`define WSFB_OFF_ACC     4'h2
`define WSFB_X_HI        23
`define WSFB_X_LO        20
`define WSFB_OP_HI       19
`define WSFB_OP_LO       14
`define WSFB_SEL_HI      13
`define WSFB_SEL_LO      10
`define WSFB_CNT_HI      9
`define WSFB_SIGN        24
`define WSFB_OP_TSI      6'h30
`define WSFB_OP_DSR      6'h20
`define WSFB_OP_DSL      6'h21
`define WSFB_OP_CSR      6'h22
`define WSFB_OP_CSL      6'h23
`define WSFB_OP_ROT      6'h24
`define WSFB_FILL_DIG    4'h3
`define WSFB_FILL_CHR    6'h00
`define WSFB_CYC_TSI_SET 4'h1
`define WSFB_CYC_TSI_CLR 4'h2
`define WSFB_CYC_DSR_1W  4'h4
`define WSFB_CYC_DSR_2W  4'h7
`define WSFB_CYC_DSR_MID 4'h4
`define WSFB_CYC_DSL_1W  4'h3
`define WSFB_CYC_DSL_2W  4'h6
`define WSFB_CYC_DSL_MID 4'h3
`define WSFB_CYC_CSR_1W  4'h4
`define WSFB_CYC_CSR_2W  4'h9
`define WSFB_CYC_CSR_MID 4'h4
`define WSFB_CYC_CSL_1W  4'h3
`define WSFB_CYC_CSL_2W  4'h8
`define WSFB_CYC_CSL_MID 4'h3
`define WSFB_CYC_ROT_A   4'h4
`define WSFB_CYC_ROT_B   4'h5
`define WSFB_CYC_ROT_C   4'h6
`define WSFB_DIG_MID_LO  15'h0007
`define WSFB_DIG_MID_HI  15'h000c
`define WSFB_CHR_MID_LO  15'h0005
`define WSFB_CHR_MID_HI  15'h0008
`define WSFB_ROT_A_HI    5'h07
`define WSFB_ROT_B_HI    5'h10
`define WSFB_ROT_WRAP    5'h19
`define WSFB_RST_PC      15'h0000
`define WSFB_RST_FLAGS   8'h00
`define WSFB_RST_INDEX   15'h0000
`endif

/* File: include/wsfb_pkg.sv */
// shared types of the shifter and flag branch block
package wsfb_pkg;
  typedef logic [24:0] wsfb_word_t;
  typedef logic [14:0] wsfb_addr_t;
  typedef enum logic {wsfb_idle, wsfb_run} wsfb_state_t;
endpackage

/* File: src/wsfb_core.sv */
// shifter and flag branch execution unit with an apb register port
// How it works
// - opcode 60: set flag jumps, else pc+1
// - branch takes one cycle set, two clear
// - testing a flag never alters it
// - count in bits 10..1, plus index
// - only selected words written, others kept
// - digit and character shifts keep signs
// - digit right shift fills left with 0011
// - digit right: 4, 7, or 4 mid
// - digit left shift fills right with 0011
// - digit left: 3, 6, or 3 mid
// - zero digit count only converts codes; fix_digit is identity, so the word is unchanged
// - oversize count shifts everything out
// - char right shift fills left with spaces
// - char right: 4, 9, or 4 mid
// - char left shift fills right with spaces
// - char left: 3, 8, or 3 mid
// - zero char or rotate count: no change
// - rotate right one word incl. sign
// - rotate takes 4, 5 or 6 cycles
// - rotate uses low five bits, wraps 25
// - count used as given, no field select
// - flag codes 1000..1111 name flags 1..8
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ns
`include "wsfb_map.svh"
module wsfb_core
  import wsfb_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // apb slave
  input  wire logic [7:0]  paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // execution status
  output logic             busy_o,
  output logic             done_o
);

  // architectural state
  wsfb_word_t  acc_reg [4];      // accumulator words
  wsfb_addr_t  pc_reg;           // program counter
  wsfb_addr_t  index_reg;        // index modifier value
  logic [7:0]  flags_reg;        // sense flags 1..8
  logic        bad_op_reg;       // last instruction unknown
  logic [3:0]  last_cyc_reg;     // cycles of last instruction

  // sequencing state
  wsfb_state_t state_reg;        // idle or running
  logic [3:0]  cyc_reg;          // cycles left minus one
  wsfb_word_t  res_hi_reg;       // pending result, first word
  wsfb_word_t  res_lo_reg;       // pending result, second word
  logic [1:0]  sel_hi_reg;       // first word select
  logic [1:0]  sel_lo_reg;       // second word select
  logic        wr_hi_reg;        // first word to be written
  logic        wr_lo_reg;        // second word to be written
  wsfb_addr_t  pc_new_reg;       // pending program counter

  // decode of the incoming instruction word
  wsfb_word_t  ir;               // instruction from the bus
  logic [3:0]  ir_x;             // index designator
  logic [5:0]  ir_op;            // opcode
  logic [3:0]  ir_sel;           // flag or word designator
  logic [1:0]  sel_hi;           // first word
  logic [1:0]  sel_lo;           // second word
  logic        two;              // two-word operand
  wsfb_addr_t  cnt;              // indexed count or target
  logic        flag_hit;         // tested flag is set
  logic [4:0]  rot_n;            // effective rotate amount
  logic [47:0] opnd;             // packed data of operand
  logic [47:0] shf;              // shifted packed data
  wsfb_word_t  new_hi;           // result first word
  wsfb_word_t  new_lo;           // result second word
  logic [3:0]  cyc_n;            // cycles for this instruction
  logic        known_op;         // opcode handled here

  // bus side decode
  logic        setup;            // apb setup phase
  logic        access;           // apb access phase
  logic        mapped;           // address hits a register
  logic        refused;          // write blocked while busy
  logic        wr_ok;            // write takes effect
  logic        go;               // instruction accepted
  logic        commit;           // last cycle of execution
  logic [31:0] rd_val;           // read mux

  // non-numeric digit hook, identity until a table is fixed
  function automatic logic [3:0] fix_digit(input logic [3:0] d);
    return d;
  endfunction

  // address decode, used by read and write paths
  function automatic logic is_mapped(input logic [7:0] a);
    logic r;
    r = 1'b0;
    if (a[1:0] == 2'b00) begin
      if (a[7:4] == `WSFB_OFF_ACC) begin
        r = 1'b1;
      end else if (a <= `WSFB_OFF_STATUS) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  // digit shift over npos four-bit positions
  function automatic logic [47:0] dig_shift(
    input logic [47:0] d,
    input int          npos,
    input int          n,
    input logic        left
  );
    logic [47:0] r;
    int          s;
    r = '0;
    s = 0;
    for (int i = 0; i < 12; i++) begin
      s = left ? i - n : i + n;
      if (i < npos) begin
        if (s >= 0 && s < npos) begin
          r[i*4 +: 4] = fix_digit(d[s*4 +: 4]);
        end else begin
          r[i*4 +: 4] = `WSFB_FILL_DIG;
        end
      end
    end
    return r;
  endfunction

  // character shift over npos six-bit positions
  function automatic logic [47:0] chr_shift(
    input logic [47:0] d,
    input int          npos,
    input int          n,
    input logic        left
  );
    logic [47:0] r;
    int          s;
    r = '0;
    s = 0;
    for (int i = 0; i < 8; i++) begin
      s = left ? i - n : i + n;
      if (i < npos) begin
        if (s >= 0 && s < npos) begin
          r[i*6 +: 6] = d[s*6 +: 6];
        end else begin
          r[i*6 +: 6] = `WSFB_FILL_CHR;
        end
      end
    end
    return r;
  endfunction

  // cycle count per opcode, operand size and count
  function automatic logic [3:0] cyc_of(
    input logic [5:0] op,
    input logic       tw,
    input wsfb_addr_t c,
    input logic [4:0] rn,
    input logic       hit
  );
    logic [3:0] r;
    logic       dmid;
    logic       cmid;
    r = 4'h1;
    dmid = (c >= `WSFB_DIG_MID_LO) && (c <= `WSFB_DIG_MID_HI);
    cmid = (c >= `WSFB_CHR_MID_LO) && (c <= `WSFB_CHR_MID_HI);
    case (op)
      `WSFB_OP_TSI: begin
        r = hit ? `WSFB_CYC_TSI_SET : `WSFB_CYC_TSI_CLR;
      end
      `WSFB_OP_DSR: begin
        r = !tw ? `WSFB_CYC_DSR_1W :
            dmid ? `WSFB_CYC_DSR_MID : `WSFB_CYC_DSR_2W;
      end
      `WSFB_OP_DSL: begin
        r = !tw ? `WSFB_CYC_DSL_1W :
            dmid ? `WSFB_CYC_DSL_MID : `WSFB_CYC_DSL_2W;
      end
      `WSFB_OP_CSR: begin
        r = !tw ? `WSFB_CYC_CSR_1W :
            cmid ? `WSFB_CYC_CSR_MID : `WSFB_CYC_CSR_2W;
      end
      `WSFB_OP_CSL: begin
        r = !tw ? `WSFB_CYC_CSL_1W :
            cmid ? `WSFB_CYC_CSL_MID : `WSFB_CYC_CSL_2W;
      end
      `WSFB_OP_ROT: begin
        if (rn <= `WSFB_ROT_A_HI) begin
          r = `WSFB_CYC_ROT_A;
        end else if (rn <= `WSFB_ROT_B_HI) begin
          r = `WSFB_CYC_ROT_B;
        end else begin
          r = `WSFB_CYC_ROT_C;
        end
      end
      default: begin
        r = 4'h1;
      end
    endcase
    return r;
  endfunction

  // field split of the written instruction
  assign ir     = pwdata_i[24:0];
  assign ir_x   = ir[`WSFB_X_HI:`WSFB_X_LO];
  assign ir_op  = ir[`WSFB_OP_HI:`WSFB_OP_LO];
  assign ir_sel = ir[`WSFB_SEL_HI:`WSFB_SEL_LO];
  assign sel_hi = ir_sel[3:2];
  assign sel_lo = ir_sel[1:0];
  assign two    = (sel_hi != sel_lo);

  // count is modified only when an index is named; indirect
  // resolution happens upstream, so the count is used as given
  assign cnt = {5'h00, ir[`WSFB_CNT_HI:0]} +
               ((ir_x != 4'h0) ? index_reg : `WSFB_RST_INDEX);

  // only codes with the top bit set name a flag
  assign flag_hit = ir_sel[3] & flags_reg[ir_sel[2:0]];

  // rotate amount from the low five bits, wrapped past 25
  always_comb begin
    rot_n = cnt[4:0];
    if (cnt[4:0] > `WSFB_ROT_WRAP) begin
      rot_n = cnt[4:0] - `WSFB_ROT_WRAP;
    end
  end

  // packed operand data, signs left out
  always_comb begin
    if (two) begin
      opnd = {acc_reg[sel_hi][23:0], acc_reg[sel_lo][23:0]};
    end else begin
      opnd = {24'h000000, acc_reg[sel_lo][23:0]};
    end
  end

  // shift datapath and result words
  always_comb begin
    logic [49:0] dbl;
    dbl    = {acc_reg[sel_lo], acc_reg[sel_lo]};
    shf    = opnd;
    new_hi = acc_reg[sel_hi];
    new_lo = acc_reg[sel_lo];
    case (ir_op)
      `WSFB_OP_DSR: begin
        shf = dig_shift(opnd, two ? 12 : 6, int'(cnt), 1'b0);
      end
      `WSFB_OP_DSL: begin
        shf = dig_shift(opnd, two ? 12 : 6, int'(cnt), 1'b1);
      end
      `WSFB_OP_CSR: begin
        shf = chr_shift(opnd, two ? 8 : 4, int'(cnt), 1'b0);
      end
      `WSFB_OP_CSL: begin
        shf = chr_shift(opnd, two ? 8 : 4, int'(cnt), 1'b1);
      end
      default: begin
        shf = opnd;
      end
    endcase
    if (ir_op == `WSFB_OP_ROT) begin
      // the sign takes part, both halves of dbl are the word
      new_lo = wsfb_word_t'(dbl >> rot_n);
    end else if (two) begin
      new_hi = {acc_reg[sel_hi][`WSFB_SIGN], shf[47:24]};
      new_lo = {acc_reg[sel_lo][`WSFB_SIGN], shf[23:0]};
    end else begin
      new_lo = {acc_reg[sel_lo][`WSFB_SIGN], shf[23:0]};
    end
  end

  // opcode classes handled by this unit
  always_comb begin
    case (ir_op)
      `WSFB_OP_TSI,
      `WSFB_OP_DSR,
      `WSFB_OP_DSL,
      `WSFB_OP_CSR,
      `WSFB_OP_CSL,
      `WSFB_OP_ROT: begin
        known_op = 1'b1;
      end
      default: begin
        known_op = 1'b0;
      end
    endcase
  end

  assign cyc_n = cyc_of(ir_op, two, cnt, rot_n, flag_hit);

  // apb phases; the slave never inserts wait states
  assign setup   = psel_i & ~penable_i;
  assign access  = psel_i & penable_i;
  assign mapped  = is_mapped(paddr_i);
  // while running, only the flags may be written
  assign refused = pwrite_i & (state_reg == wsfb_run) &
                   (paddr_i != `WSFB_OFF_FLAGS) &
                   (paddr_i != `WSFB_OFF_STATUS);
  assign wr_ok   = access & pwrite_i & mapped & ~refused;
  assign go      = wr_ok & (paddr_i == `WSFB_OFF_INSTR);
  assign commit  = (state_reg == wsfb_run) & (cyc_reg == 4'h0);

  assign pready_o  = 1'b1;
  assign pslverr_o = access & (~mapped | refused);
  assign busy_o    = (state_reg == wsfb_run);

  // sequencer: counts the documented cycles of each instruction
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= wsfb_idle;
      cyc_reg   <= 4'h0;
      done_o    <= 1'b0;
    end else begin
      done_o <= commit;
      case (state_reg)
        wsfb_idle: begin
          if (go && known_op) begin
            state_reg <= wsfb_run;
            cyc_reg   <= cyc_n - 4'h1;
          end
        end
        wsfb_run: begin
          if (cyc_reg == 4'h0) begin
            state_reg <= wsfb_idle;
          end else begin
            cyc_reg <= cyc_reg - 4'h1;
          end
        end
        default: begin
          state_reg <= wsfb_idle;
        end
      endcase
    end
  end

  // results are frozen at acceptance and applied at the end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      res_hi_reg <= '0;
      res_lo_reg <= '0;
      sel_hi_reg <= 2'h0;
      sel_lo_reg <= 2'h0;
      wr_hi_reg  <= 1'b0;
      wr_lo_reg  <= 1'b0;
      pc_new_reg <= `WSFB_RST_PC;
    end else if (go && known_op) begin
      res_hi_reg <= new_hi;
      res_lo_reg <= new_lo;
      sel_hi_reg <= sel_hi;
      sel_lo_reg <= sel_lo;
      wr_hi_reg  <= two & (ir_op != `WSFB_OP_TSI) &
                    (ir_op != `WSFB_OP_ROT);
      wr_lo_reg  <= (ir_op != `WSFB_OP_TSI);
      if (ir_op == `WSFB_OP_TSI && flag_hit) begin
        pc_new_reg <= cnt;
      end else begin
        pc_new_reg <= pc_reg + 15'h0001;
      end
    end
  end

  // accumulator words: bus writes when idle, results at commit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 4; i++) begin
        acc_reg[i] <= '0;
      end
    end else begin
      if (wr_ok && paddr_i[7:4] == `WSFB_OFF_ACC) begin
        acc_reg[paddr_i[3:2]] <= pwdata_i[24:0];
      end
      if (commit && wr_lo_reg) begin
        acc_reg[sel_lo_reg] <= res_lo_reg;
      end
      if (commit && wr_hi_reg) begin
        acc_reg[sel_hi_reg] <= res_hi_reg;
      end
    end
  end

  // program counter
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_reg <= `WSFB_RST_PC;
    end else if (commit) begin
      pc_reg <= pc_new_reg;
    end else if (wr_ok && paddr_i == `WSFB_OFF_PC) begin
      pc_reg <= pwdata_i[14:0];
    end
  end

  // index value and sense flags; a test never writes flags
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      index_reg <= `WSFB_RST_INDEX;
      flags_reg <= `WSFB_RST_FLAGS;
    end else begin
      if (wr_ok && paddr_i == `WSFB_OFF_INDEX) begin
        index_reg <= pwdata_i[14:0];
      end
      if (wr_ok && paddr_i == `WSFB_OFF_FLAGS) begin
        flags_reg <= pwdata_i[7:0];
      end
    end
  end

  // status: unknown opcode and cycle count of the last accept
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bad_op_reg   <= 1'b0;
      last_cyc_reg <= 4'h0;
    end else if (go) begin
      bad_op_reg   <= ~known_op;
      last_cyc_reg <= known_op ? cyc_n : 4'h0;
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    rd_val = 32'h00000000;
    if (paddr_i[7:4] == `WSFB_OFF_ACC) begin
      rd_val = {7'h00, acc_reg[paddr_i[3:2]]};
    end else begin
      case (paddr_i)
        `WSFB_OFF_INDEX:  rd_val = {17'h00000, index_reg};
        `WSFB_OFF_PC:     rd_val = {17'h00000, pc_reg};
        `WSFB_OFF_FLAGS:  rd_val = {24'h000000, flags_reg};
        `WSFB_OFF_STATUS: rd_val = {24'h000000, last_cyc_reg,
                                    2'b00, bad_op_reg, busy_o};
        default:          rd_val = 32'h00000000;
      endcase
    end
  end

  // read data captured in setup, held through the access
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h00000000;
    end else if (setup && !pwrite_i) begin
      prdata_o <= mapped ? rd_val : 32'h00000000;
    end
  end

endmodule

/* File: tb/wsfb_core_chk.sv */
// concurrent checks on the apb and status ports of the shifter core
`timescale 1ns/1ns
`include "wsfb_map.svh"
module wsfb_core_chk (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // apb slave side
  input wire logic [7:0]  paddr_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // execution status
  input wire logic        busy_o,
  input wire logic        done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic       wr_now;   // apb write completing at this edge
  logic       go;       // instruction taken at this edge
  logic       one_w;    // both word selects equal
  logic       flag_hit; // tested flag set in the shadow copy
  logic       rot_x0;   // rotate with no index register
  logic [5:0] op;       // opcode field of the write data
  logic [7:0] flag_q;   // shadow of the sense flags
  assign op = pwdata_i[19:14];
  assign wr_now = psel_i && penable_i && pwrite_i && pready_o;
  assign go = wr_now && paddr_i == `WSFB_OFF_INSTR && !busy_o;
  assign one_w = pwdata_i[13:12] == pwdata_i[11:10];
  assign flag_hit = pwdata_i[13] && flag_q[pwdata_i[12:10]];
  assign rot_x0 = go && op == `WSFB_OP_ROT && pwdata_i[23:20] == 4'h0;
  // shadow follows software writes only, the branch never touches it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_q <= 8'h00;
    end else if (wr_now && paddr_i == `WSFB_OFF_FLAGS) begin
      flag_q <= pwdata_i[7:0];
    end
  end
  // busy held for an exact number of cycles, then released
  sequence s_run1; busy_o ##1 !busy_o; endsequence
  sequence s_run2; busy_o [*2] ##1 !busy_o; endsequence
  sequence s_run3; busy_o [*3] ##1 !busy_o; endsequence
  sequence s_run4; busy_o [*4] ##1 !busy_o; endsequence
  sequence s_run5; busy_o [*5] ##1 !busy_o; endsequence
  AST_TSI_SET: assert property (
    go && op == `WSFB_OP_TSI && flag_hit |=> s_run1)
    else $error("taken flag branch not one cycle");
  AST_TSI_CLR: assert property (
    go && op == `WSFB_OP_TSI && !flag_hit |=> s_run2)
    else $error("untaken flag branch not two cycles");
  AST_DSR_ONE: assert property (
    go && op == `WSFB_OP_DSR && one_w |=> s_run4)
    else $error("one-word digit right shift not four cycles");
  AST_DSL_ONE: assert property (
    go && op == `WSFB_OP_DSL && one_w |=> s_run3)
    else $error("one-word digit left shift not three cycles");
  AST_CSR_ONE: assert property (
    go && op == `WSFB_OP_CSR && one_w |=> s_run4)
    else $error("one-word char right shift not four cycles");
  AST_CSL_ONE: assert property (
    go && op == `WSFB_OP_CSL && one_w |=> s_run3)
    else $error("one-word char left shift not three cycles");
  AST_ROT_LOW: assert property (
    rot_x0 && pwdata_i[9:3] == 7'h00 |=> s_run4)
    else $error("short rotate not four cycles");
  AST_ROT_MID: assert property (
    rot_x0 && pwdata_i[9:0] >= 10'h008 && pwdata_i[9:0] <= 10'h010
    |=> s_run5) else $error("middle rotate not five cycles");
  AST_DONE_PULSE: assert property (
    $fell(busy_o) |-> done_o ##1 !done_o)
    else $error("done not a single pulse after busy");
  AST_FLAGS_KEPT: assert property (
    psel_i && penable_i && !pwrite_i && paddr_i == `WSFB_OFF_FLAGS
    |-> prdata_o[7:0] == flag_q) else $error("sense flags altered");
endmodule
bind wsfb_core wsfb_core_chk i_wsfb_core_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .paddr_i(paddr_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .busy_o(busy_o), .done_o(done_o)
);

/* File: tb/wsfb_host.sv */
// apb master standing in for the decode and sequencing logic
`timescale 1ns/1ns
module wsfb_host (
  // clock
  input  wire logic        clk_i,
  // apb master side
  output logic [7:0]       paddr_o,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [31:0]      pwdata_o,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i
);
  int gap; // idle cycles before a transfer, makes the master slow
  // bus idle at time zero
  initial begin
    gap       = 0;
    paddr_o   = 8'h00;
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    pwdata_o  = 32'h0;
  end
  // one transfer; request held until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err, output logic tmo);
    int k;
    k = 0;
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= wr;
    paddr_o   <= a;
    pwdata_o  <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_i !== 1'b1 && k < 20);
    q   = prdata_i;
    err = pslverr_i;
    tmo = pready_i !== 1'b1;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    // released lines must not keep looking valid
    paddr_o   <= ~a;
    pwdata_o  <= ~d;
  endtask
endmodule

/* File: tb/test_word_shifter_and_flag_branch.sv */
// self-checking bench for the shifter and flag branch core
`timescale 1ns/1ns
`include "wsfb_map.svh"
module test_word_shifter_and_flag_branch import wsfb_pkg::*;;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        busy, done, e;   // status and last bus error
  logic [7:0]  paddr;           // apb address
  logic [31:0] pwdata, prdata, q, ins; // bus data, instruction
  logic [3:0]  sel;             // word select field
  wsfb_word_t  m_acc [4];       // model accumulator words
  wsfb_addr_t  m_pc, m_idx;     // model counter and index
  logic [7:0]  m_flg;           // model sense flags
  int          num_errors, cmp_count;
  logic [5:0]  s_ops [4] = '{`WSFB_OP_DSR, `WSFB_OP_DSL,
                             `WSFB_OP_CSR, `WSFB_OP_CSL};
  // counts at the edges of size and timing bands, first two one-word
  int s_cts [12] = '{0, 9, 0, 4, 5, 6, 7, 8, 9, 12, 13, 30};
  int r_cts [10] = '{0, 7, 8, 16, 17, 25, 26, 31, 127, 1023};
  wsfb_core i_wsfb_core (.clk_i(clk), .rst_n_i(rst_n), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .busy_o(busy), .done_o(done));
  wsfb_host i_wsfb_host (.clk_i(clk), .paddr_o(paddr), .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .pwdata_o(pwdata),
    .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));
  // 20 ns clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer, result left in q and e
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    logic t;
    i_wsfb_host.xfer(wr, a, d, q, e, t);
    if (t) begin
      num_errors++;
      $display("MISMATCH t=%0t bus timeout", $time);
      give_verdict();
    end
  endtask
  function automatic logic [31:0] mk(input logic [3:0] x,
    input logic [5:0] op, input logic [3:0] s, input logic [9:0] m);
    return {8'h00, x, op, s, m};
  endfunction
  // reference behaviour of one instruction
  task automatic model(input logic [31:0] w, output int cyc);
    logic [14:0] cnt;
    logic [5:0]  op;
    logic [1:0]  sa, sb;
    logic [63:0] d, msk;
    logic [49:0] rr;
    int          nb, st, n, r;
    bit          tw, mid;
    op  = w[19:14];
    sa  = w[13:12];
    sb  = w[11:10];
    tw  = sa != sb;
    cnt = w[9:0] + (w[23:20] != 4'h0 ? m_idx : 15'h0000);
    m_pc = m_pc + 15'h0001;
    st  = (op == `WSFB_OP_DSR || op == `WSFB_OP_DSL) ? 4 : 6;
    nb  = tw ? 48 : 24;
    msk = (64'h1 << nb) - 64'h1;
    d   = {16'h0, tw ? m_acc[sa][23:0] : 24'h0, m_acc[sb][23:0]};
    n   = cnt > nb / st ? nb / st : int'(cnt);
    mid = st == 4 ? (cnt >= 7 && cnt <= 12) : (cnt >= 5 && cnt <= 8);
    for (int i = 0; i < n; i++) begin
      if (op[0]) begin
        d = ((d << st) | (st == 4 ? 64'h3 : 64'h0)) & msk;
      end else begin
        d = (d >> st) | ((st == 4 ? 64'h3 : 64'h0) << (nb - st));
      end
    end
    case (op)
      `WSFB_OP_TSI: begin
        cyc = 2;
        if (w[13] && m_flg[w[12:10]]) begin
          m_pc = cnt;
          cyc = 1;
        end
      end
      `WSFB_OP_ROT: begin
        r = cnt[4:0] > 25 ? cnt[4:0] - 25 : cnt[4:0];
        rr = {m_acc[sb], m_acc[sb]} >> r;
        m_acc[sb] = rr[24:0];
        cyc = r <= 7 ? 4 : (r <= 16 ? 5 : 6);
      end
      default: begin
        m_acc[sb][23:0] = d[23:0];
        if (tw) m_acc[sa][23:0] = d[47:24];
        cyc = (!tw || mid) ? (op[0] ? 3 : 4) :
              (st == 4 ? (op[0] ? 6 : 7) : (op[0] ? 8 : 9));
      end
    endcase
  endtask
  // compare every word and the counter with the model
  task automatic cmp_all;
    for (int k = 0; k < 4; k++) begin
      bus(1'b0, 8'h20 + 8'(4 * k), 32'h0);
      chk(q, {7'h0, m_acc[k]});
    end
    bus(1'b0, `WSFB_OFF_PC, 32'h0);
    chk(q, {17'h0, m_pc});
  endtask
  // random words, index and flags
  task automatic load;
    for (int k = 0; k < 4; k++) begin
      m_acc[k] = wsfb_word_t'($urandom);
      bus(1'b1, 8'h20 + 8'(4 * k), {7'h0, m_acc[k]});
    end
    m_idx = wsfb_addr_t'($urandom_range(0, 20));
    m_flg = 8'($urandom);
    bus(1'b1, `WSFB_OFF_INDEX, {17'h0, m_idx});
    bus(1'b1, `WSFB_OFF_FLAGS, {24'h0, m_flg});
  endtask
  // issue, count busy cycles, check the done pulse and results
  task automatic run(input logic [31:0] w, input bit ck);
    int n, c;
    model(w, c);
    bus(1'b1, `WSFB_OFF_INSTR, w);
    #1;
    n = 0;
    while (busy === 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    // a busy that never drops is a failure, not a silent pass
    if (n >= 40) begin
      num_errors++;
      $display("MISMATCH t=%0t busy stuck", $time);
      give_verdict();
    end
    if (ck) chk(32'(n), 32'(c));
    chk({31'h0, done}, 32'h1);
    cmp_all();
    bus(1'b0, `WSFB_OFF_STATUS, 32'h0);
    chk(q, 32'(c) << 4);
  endtask
  initial begin
    rst_n      = 1'b0;
    num_errors = 0;
    cmp_count  = 0;
    m_pc       = 15'h0000;
    m_idx      = 15'h0000;
    m_flg      = 8'h00;
    m_acc      = '{default: 25'h0};
    void'($urandom(14047));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    cmp_all();
    bus(1'b0, 8'h3c, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    // every select code, master prompt and slow in turn
    for (int s = 0; s < 16; s++) begin
      load();
      i_wsfb_host.gap = s % 3;
      ins = mk(4'($urandom_range(0, 2)), `WSFB_OP_TSI, 4'(s), 10'($urandom));
      run(ins, 1'b1);
      bus(1'b0, `WSFB_OFF_FLAGS, 32'h0);
      chk(q, {24'h0, m_flg});
    end
    foreach (s_ops[o]) begin
      foreach (s_cts[t]) begin
        load();
        sel = 4'($urandom);
        sel[3:2] = t < 2 ? sel[1:0] : sel[1:0] + 2'($urandom_range(1, 3));
        ins = mk(4'h0, s_ops[o], sel, 10'(s_cts[t]));
        run(ins, 1'b1);
      end
      load();
      ins = mk(4'h1, s_ops[o], 4'($urandom), 10'($urandom_range(0, 9)));
      run(ins, 1'b1);
    end
    foreach (r_cts[i]) begin
      load();
      ins = mk(4'h0, `WSFB_OP_ROT, 4'($urandom), 10'(r_cts[i]));
      run(ins, 1'b1);
    end
    load();
    ins = mk(4'h2, `WSFB_OP_ROT, 4'h5, 10'h003) | 32'h0100_0000;
    run(ins, 1'b1);
    // unknown opcode: not run, flagged in status, counter kept
    bus(1'b1, `WSFB_OFF_INSTR, mk(4'h0, 6'h3f, 4'h0, 10'h000));
    bus(1'b0, `WSFB_OFF_STATUS, 32'h0);
    chk(q, 32'h00000002);
    cmp_all();
    give_verdict();
  end
endmodule
